/* core/dpcc_pkg.sv */
package dpcc_pkg;

    // Register byte addresses on the 16-bit register port
    localparam logic [15:0] ADDR_DBL_CLK = 16'h5071;
    localparam logic [15:0] ADDR_BST_CLK = 16'h5072;
    localparam logic [15:0] ADDR_CORE_REG = 16'h5120;
    localparam logic [15:0] ADDR_PWR0 = 16'h5600;

    // Booster clock control field positions
    localparam int BST_GATE_BIT = 0;
    localparam int BST_SRC_LSB = 2;
    localparam int BST_DIV_LSB = 4;
    // Doubler clock control field position
    localparam int DBL_GATE_BIT = 0;
    // Core regulator control field position
    localparam int CORE_HEAVY_BIT = 5;
    // Display power control 0 field positions
    localparam int PWR_REF_ON_BIT = 0;
    localparam int PWR_REF_SEL_BIT = 1;
    localparam int PWR_REF_HEAVY_BIT = 2;
    localparam int PWR_CONTRAST_LSB = 4;
    localparam int PWR_DBL_ON_BIT = 8;
    localparam int PWR_DBL_BYPASS_BIT = 9;

    // Reset values
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [3:0] CONTRAST_RESET = 4'h7;

    // Booster source encodings
    localparam logic [1:0] SRC_INTERNAL_HF = 2'h0;
    localparam logic [1:0] SRC_LOW_SPEED = 2'h1;
    localparam logic [1:0] SRC_PRIMARY_HF = 2'h2;

    // Oscillator input lanes in the synchroniser bank
    localparam int OSC_LANES = 4;
    localparam int LANE_INTERNAL = 0;
    localparam int LANE_PRIMARY = 1;
    localparam int LANE_LOW = 2;
    localparam int LANE_DOUBLER = 3;

    // Analogue control levels, all held in flip-flops
    typedef struct packed {
        logic core_reg_heavy_load;
        logic doubler_bypass;
        logic doubler_on;
        logic [3:0] ref_contrast;
        logic ref_heavy_load;
        logic ref_level_sel;
        logic ref_regulator_on;
    } dpcc_analog_type;

endpackage : dpcc_pkg

/* core/dpcc_top.sv */
`timescale 1ns/1ps
// Contract
// R1: Booster gate 1 passes divided clock
// R2: Source field selects booster oscillator
// R3: Internal oscillator divide codes 2..5
// R4: Primary oscillator divide codes 1..5
// R5: Low-speed oscillator divide codes 0..3
// R6: Software clears booster gate when idle
// R7: Doubler gate 1 delivers doubler clock
// R8: Software clears doubler gate when idle
// R9: Core bit 5 sets heavy load
// R10: Bypass bit shorts doubler input/output
// R11: Contrast field drives reference level
// R12: Bit 2 sets reference heavy load
// R13: Reserved bits read zero, writes ignored
// R14: Bit 8 turns doubler on
// R15: Running doubler is never shorted
// R16: Bit 1 selects reference level
// R17: Bit 0 turns reference regulator on
module dpcc_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_internal_hf_osc,
    input wire logic i_primary_hf_osc,
    input wire logic i_low_speed_osc,
    input wire logic i_doubler_src_clk,
    output logic [15:0] o_rdata,
    output logic o_booster_clk,
    output logic o_doubler_clk,
    output dpcc_pkg::dpcc_analog_type o_analog
);
    import dpcc_pkg::*;

    // Exponent of the divide ratio, bit 4 marks a legal combination
    function automatic logic [4:0] dpcc_rate(input logic [1:0] src, input logic [2:0] div);
        logic [4:0] r;
        r = 5'h00;
        case (src)
            SRC_INTERNAL_HF:
            begin
                // Codes 2..5 give 1/16 .. 1/128
                if (div >= 3'h2 && div <= 3'h5) r = {1'b1, 4'(div) + 4'h2}; // R3
            end
            SRC_PRIMARY_HF:
            begin
                // Codes 1..5 give 1/16 .. 1/256
                // Widened before the add, code 5 would wrap in three bits
                if (div >= 3'h1 && div <= 3'h5) r = {1'b1, 4'(div) + 4'h3}; // R4
            end
            SRC_LOW_SPEED:
            begin
                // Codes 0..3 give 1/1 .. 1/8
                if (div <= 3'h3) r = {1'b1, 1'b0, div}; // R5
            end
            default:
            begin
                // Reserved source never produces a clock
                r = 5'h00; // R2
            end
        endcase
        return r;
    endfunction : dpcc_rate

    // Register storage
    logic bst_gate_q; // Booster clock gate
    logic [1:0] bst_src_q; // Booster source select
    logic [2:0] bst_div_q; // Booster divide select
    logic dbl_gate_q; // Doubler clock gate
    logic core_heavy_q; // Core and oscillator heavy load
    logic dbl_bypass_q; // Doubler short request
    logic dbl_on_q; // Doubler enable
    logic [3:0] contrast_q; // Reference contrast level
    logic ref_heavy_q; // Reference heavy load
    logic ref_sel_q; // Reference level select
    logic ref_on_q; // Reference regulator enable

    // Address decode
    wire logic hit_dbl = (i_addr == ADDR_DBL_CLK);
    wire logic hit_bst = (i_addr == ADDR_BST_CLK);
    wire logic hit_core = (i_addr == ADDR_CORE_REG);
    wire logic hit_pwr = (i_addr == ADDR_PWR0);
    wire logic wr_dbl = i_wr && hit_dbl;
    wire logic wr_bst = i_wr && hit_bst;
    wire logic wr_core = i_wr && hit_core;
    wire logic wr_pwr = i_wr && hit_pwr;

    // Read images, reserved positions tied to zero
    wire logic [15:0] img_dbl = {15'h0000, dbl_gate_q}; // R13
    wire logic [15:0] img_bst = {8'h00, 1'b0, bst_div_q, bst_src_q, 1'b0, bst_gate_q}; // R13
    wire logic [15:0] img_core = {10'h000, core_heavy_q, 5'h00}; // R13
    wire logic [15:0] img_pwr = {6'h00, dbl_bypass_q, dbl_on_q, contrast_q, 1'b0, ref_heavy_q,
        ref_sel_q, ref_on_q}; // R13
    // Unmapped addresses read as zero
    wire logic [15:0] rdata_d = !i_rd ? 16'h0000 :
        hit_dbl ? img_dbl :
        hit_bst ? img_bst :
        hit_core ? img_core :
        hit_pwr ? img_pwr : 16'h0000;

    // Clock control registers; only named fields are stored
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bst_gate_q <= 1'b0;
            bst_src_q <= SRC_RESET;
            bst_div_q <= DIV_RESET;
            dbl_gate_q <= 1'b0;
        end
        else
        begin
            // Booster clock control
            if (wr_bst)
            begin
                bst_gate_q <= i_wdata[BST_GATE_BIT]; // R1
                bst_src_q <= i_wdata[BST_SRC_LSB +: 2]; // R2
                bst_div_q <= i_wdata[BST_DIV_LSB +: 3];
            end
            // Doubler clock control
            if (wr_dbl)
            begin
                dbl_gate_q <= i_wdata[DBL_GATE_BIT]; // R7
            end
        end
    end

    // Power control registers
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            core_heavy_q <= 1'b0;
            dbl_bypass_q <= 1'b0;
            dbl_on_q <= 1'b0;
            contrast_q <= CONTRAST_RESET;
            ref_heavy_q <= 1'b0;
            ref_sel_q <= 1'b0;
            ref_on_q <= 1'b0;
        end
        else
        begin
            // Core regulator control
            if (wr_core)
            begin
                core_heavy_q <= i_wdata[CORE_HEAVY_BIT]; // R9
            end
            // Display power control 0
            if (wr_pwr)
            begin
                dbl_bypass_q <= i_wdata[PWR_DBL_BYPASS_BIT]; // R10
                dbl_on_q <= i_wdata[PWR_DBL_ON_BIT]; // R14
                contrast_q <= i_wdata[PWR_CONTRAST_LSB +: 4]; // R11
                ref_heavy_q <= i_wdata[PWR_REF_HEAVY_BIT]; // R12
                ref_sel_q <= i_wdata[PWR_REF_SEL_BIT]; // R16
                ref_on_q <= i_wdata[PWR_REF_ON_BIT]; // R17
            end
        end
    end

    // Oscillator pins come from foreign clocks
    wire logic [OSC_LANES-1:0] osc_raw = {i_doubler_src_clk, i_low_speed_osc, i_primary_hf_osc,
        i_internal_hf_osc};
    logic [OSC_LANES-1:0] osc_level; // Filtered oscillator levels

    // Three-stage synchroniser, level moves when stages one and two agree
    genvar g;
    generate
        for (g = 0; g < OSC_LANES; g++)
        begin : g_sync
            logic [2:0] sync_q; // Stage 0 feeds only stage 1
            logic level_q; // Accepted level
            always_ff @(posedge i_clock or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    sync_q <= 3'h0;
                    level_q <= 1'b0;
                end
                else
                begin
                    sync_q <= {sync_q[1:0], osc_raw[g]};
                    // A one-sample glitch never reaches the divider
                    if (sync_q[1] == sync_q[2]) level_q <= sync_q[2];
                end
            end
            assign osc_level[g] = level_q;
        end
    endgenerate

    // Source mux; the reserved code selects nothing
    wire logic src_level = (bst_src_q == SRC_INTERNAL_HF) ? osc_level[LANE_INTERNAL] :
        (bst_src_q == SRC_PRIMARY_HF) ? osc_level[LANE_PRIMARY] :
        (bst_src_q == SRC_LOW_SPEED) ? osc_level[LANE_LOW] : 1'b0; // R2
    wire logic [4:0] rate = dpcc_rate(bst_src_q, bst_div_q);
    wire logic rate_ok = rate[4];
    wire logic [3:0] rate_exp = rate[3:0];
    // Divider runs only while gated on and legal, saving current otherwise
    wire logic div_run = bst_gate_q && rate_ok; // R1
    // Rising edges of the source to toggle on every half period
    wire logic [7:0] half_m1 = (rate_exp == 4'h0) ? 8'h00 :
        8'((9'h001 << (rate_exp - 4'h1)) - 9'h001);

    logic src_prev_q; // Previous source level
    logic [7:0] cnt_q; // Edge counter within a half period
    logic div_out_q; // Divided clock level
    wire logic src_rise = src_level && !src_prev_q;
    wire logic cnt_wrap = src_rise && (cnt_q == half_m1);
    // Counter restarts on any booster write so a new ratio starts clean
    wire logic [7:0] cnt_d = (!div_run || wr_bst) ? 8'h00 :
        cnt_wrap ? 8'h00 :
        src_rise ? 8'(cnt_q + 8'h01) : cnt_q;
    wire logic div_out_d = (!div_run || wr_bst) ? 1'b0 :
        cnt_wrap ? !div_out_q : div_out_q; // R3 R4 R5
    // Ratio 1/1 forwards the filtered source level
    wire logic bst_clk_d = !div_run ? 1'b0 :
        (rate_exp == 4'h0) ? src_level : div_out_q; // R1 R5
    // Doubler clock is blocked while the gate is clear
    wire logic dbl_clk_d = dbl_gate_q && osc_level[LANE_DOUBLER]; // R7

    // Divider state
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            src_prev_q <= 1'b0;
            cnt_q <= 8'h00;
            div_out_q <= 1'b0;
        end
        else
        begin
            src_prev_q <= src_level;
            cnt_q <= cnt_d;
            div_out_q <= div_out_d;
        end
    end

    // Analogue levels; bypass is withheld while the doubler runs
    dpcc_analog_type analog_d;
    assign analog_d = '{
        core_reg_heavy_load: core_heavy_q, // R9
        doubler_bypass: dbl_bypass_q && !dbl_on_q, // R10 R15
        doubler_on: dbl_on_q, // R14
        ref_contrast: contrast_q, // R11
        ref_heavy_load: ref_heavy_q, // R12
        ref_level_sel: ref_sel_q, // R16
        ref_regulator_on: ref_on_q // R17
    };

    // Output flops
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 16'h0000;
            o_booster_clk <= 1'b0;
            o_doubler_clk <= 1'b0;
            o_analog <= '{ref_contrast: CONTRAST_RESET, default: 1'b0};
        end
        else
        begin
            o_rdata <= rdata_d;
            o_booster_clk <= bst_clk_d;
            o_doubler_clk <= dbl_clk_d;
            o_analog <= analog_d;
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_pwr_write;
        i_wr && hit_pwr;
    endsequence

    sequence s_core_write;
        i_wr && hit_core;
    endsequence

    sequence s_bst_write;
        i_wr && hit_bst;
    endsequence

    chk_booster_gate_off: assert property (!bst_gate_q |=> !o_booster_clk) // R1
        else $error("booster clock runs while gated off");
    chk_reserved_source: assert property (bst_src_q == 2'h3 |=> !o_booster_clk) // R2
        else $error("reserved booster source produced a clock");
    chk_internal_reserved: assert property ((bst_src_q == SRC_INTERNAL_HF) // R3
        && (bst_div_q < 3'h2 || bst_div_q > 3'h5) |=> !o_booster_clk)
        else $error("reserved internal divide produced a clock");
    chk_primary_reserved: assert property ((bst_src_q == SRC_PRIMARY_HF) // R4
        && (bst_div_q == 3'h0 || bst_div_q > 3'h5) |=> !o_booster_clk)
        else $error("reserved primary divide produced a clock");
    chk_low_reserved: assert property ((bst_src_q == SRC_LOW_SPEED) // R5
        && (bst_div_q > 3'h3) |=> !o_booster_clk)
        else $error("reserved low speed divide produced a clock");
    chk_low_passthru: assert property (bst_gate_q && bst_src_q == SRC_LOW_SPEED && bst_div_q == 3'h0 // R5
        |=> o_booster_clk == $past(osc_level[LANE_LOW]))
        else $error("undivided low speed clock not forwarded");
    chk_divider_bound: assert property (div_run && rate_exp != 4'h0 |-> cnt_q <= half_m1) // R3
        else $error("divider count past half period");
    chk_divider_restart: assert property (s_bst_write |=> cnt_q == 8'h00 && !div_out_q) // R1
        else $error("booster divider not restarted by write");
    chk_divider_toggle: assert property (div_run && !wr_bst && cnt_wrap // R3 R4 R5
        |=> div_out_q != $past(div_out_q))
        else $error("divided clock missed its half period edge");
    chk_divider_hold: assert property (div_run && !wr_bst && !cnt_wrap // R3 R4 R5
        |=> div_out_q == $past(div_out_q))
        else $error("divided clock moved inside a half period");
    chk_doubler_gate: assert property (!dbl_gate_q |=> !o_doubler_clk) // R7
        else $error("doubler clock runs while gated off");
    chk_doubler_follow: assert property (dbl_gate_q |=> o_doubler_clk == $past(osc_level[LANE_DOUBLER])) // R7
        else $error("gated doubler clock does not follow its source");
    chk_core_heavy: assert property (s_core_write |=> ##1 // R9
        o_analog.core_reg_heavy_load == $past(i_wdata[CORE_HEAVY_BIT], 2))
        else $error("core heavy load level mismatch");
    chk_bypass_guard: assert property (o_analog.doubler_bypass |-> $past(dbl_bypass_q) && !$past(dbl_on_q)) // R10
        else $error("doubler shorted without request or while running");
    chk_no_short_run: assert property (o_analog.doubler_on |-> !o_analog.doubler_bypass) // R15
        else $error("running doubler is shorted");
    chk_bypass_write: assert property (s_pwr_write |=> ##1 o_analog.doubler_bypass == // R10 R15
        ($past(i_wdata[PWR_DBL_BYPASS_BIT], 2) && !$past(i_wdata[PWR_DBL_ON_BIT], 2)))
        else $error("doubler short level does not follow write");
    chk_pwr_fields: assert property (s_pwr_write |=> ##1 // R11 R12 R14 R16 R17
        o_analog.ref_contrast == $past(i_wdata[PWR_CONTRAST_LSB +: 4], 2)
        && o_analog.ref_heavy_load == $past(i_wdata[PWR_REF_HEAVY_BIT], 2)
        && o_analog.ref_level_sel == $past(i_wdata[PWR_REF_SEL_BIT], 2)
        && o_analog.ref_regulator_on == $past(i_wdata[PWR_REF_ON_BIT], 2)
        && o_analog.doubler_on == $past(i_wdata[PWR_DBL_ON_BIT], 2))
        else $error("power control levels do not follow write");
    chk_reserved_read: assert property (i_rd && hit_bst |=> o_rdata[15:7] == 9'h000 && !o_rdata[1]) // R13
        else $error("reserved booster bits read nonzero");
    chk_dbl_read: assert property (i_rd && hit_dbl |=> o_rdata[15:1] == 15'h0000) // R13
        else $error("reserved doubler clock bits read nonzero");
    chk_core_read: assert property (i_rd && hit_core // R13
        |=> o_rdata[15:6] == 10'h000 && o_rdata[4:0] == 5'h00)
        else $error("reserved core regulator bits read nonzero");
    chk_pwr_read: assert property (i_rd && hit_pwr |=> o_rdata[15:10] == 6'h00 && !o_rdata[3]) // R13
        else $error("reserved power control bits read nonzero");
    chk_unmapped_read: assert property (i_rd && !(hit_dbl || hit_bst || hit_core || hit_pwr) // R13
        |=> o_rdata == 16'h0000)
        else $error("unmapped address read nonzero");
    chk_read_window: assert property (!i_rd |=> o_rdata == 16'h0000) // R13
        else $error("read data outside its cycle");

endmodule : dpcc_top

/* dv/dpcc_osc_model.sv */
`timescale 1ns/1ps
// Free-running on-chip oscillators of the analogue side
// Frequencies stay far below the sampling rate so the divider sees every edge
// Odd start offsets keep edges away from the bench sampling instants
module dpcc_osc_model #(
    parameter int P_INT = 200,
    parameter int P_PRI = 280,
    parameter int P_LOW = 400,
    parameter int P_DBL = 240
) (
    output logic o_internal_hf_osc,
    output logic o_primary_hf_osc,
    output logic o_low_speed_osc,
    output logic o_doubler_src_clk
);
    // Internal high-speed oscillator
    initial
    begin
        o_internal_hf_osc = 1'b0;
        #3;
        forever #(P_INT / 2) o_internal_hf_osc = ~o_internal_hf_osc;
    end
    // Primary high-speed oscillator
    initial
    begin
        o_primary_hf_osc = 1'b0;
        #7;
        forever #(P_PRI / 2) o_primary_hf_osc = ~o_primary_hf_osc;
    end
    // Low-speed oscillator
    initial
    begin
        o_low_speed_osc = 1'b0;
        #11;
        forever #(P_LOW / 2) o_low_speed_osc = ~o_low_speed_osc;
    end
    // Pre-selected doubler source
    initial
    begin
        o_doubler_src_clk = 1'b0;
        #13;
        forever #(P_DBL / 2) o_doubler_src_clk = ~o_doubler_src_clk;
    end
endmodule : dpcc_osc_model

/* dv/dpcc_top_test.sv */
`timescale 1ns/1ps
module dpcc_top_test;
    import dpcc_pkg::*;
    // Register access row: address, data, readback, analogue image
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [15:0] analog;
    } dpcc_row_type;
    // Booster setting and source edges per output period, 0 for silent
    typedef struct packed {
        logic gate;
        logic [1:0] src;
        logic [2:0] div;
        logic [8:0] n;
    } dpcc_clk_type;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic osc_int, osc_pri, osc_low, osc_dbl;
    logic [15:0] o_rdata;
    logic o_booster_clk, o_doubler_clk;
    dpcc_analog_type o_analog;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int src_edges = 0;
    int b_rises = 0;
    int d_rises = 0;
    logic b_prev = 1'b0;
    logic d_prev = 1'b0;
    logic [1:0] src_now = 2'h0;
    logic src_wave;
    int r0, e0, k;
    // Later rows depend on state left by earlier ones
    dpcc_row_type rows [8] = '{
        '{16'h5600, 16'hFFFF, 16'h03F7, 16'h00FF},
        '{16'h5600, 16'h0200, 16'h0200, 16'h0100},
        '{16'h5600, 16'h00A5, 16'h00A5, 16'h0055},
        '{16'h5120, 16'hFFFF, 16'h0020, 16'h0255},
        '{16'h5120, 16'h0000, 16'h0000, 16'h0055},
        '{16'h5072, 16'hFFFE, 16'h007C, 16'h0055},
        '{16'h5071, 16'hFFFE, 16'h0000, 16'h0055},
        '{16'h5602, 16'hFFFF, 16'h0000, 16'h0055}};
    dpcc_clk_type clks [20] = '{
        '{1'b1, 2'h0, 3'h2, 9'd16}, '{1'b1, 2'h0, 3'h3, 9'd32}, '{1'b1, 2'h0, 3'h4, 9'd64},
        '{1'b1, 2'h0, 3'h5, 9'd128}, '{1'b1, 2'h0, 3'h1, 9'd0}, '{1'b1, 2'h0, 3'h6, 9'd0},
        '{1'b1, 2'h2, 3'h1, 9'd16}, '{1'b1, 2'h2, 3'h2, 9'd32}, '{1'b1, 2'h2, 3'h3, 9'd64},
        '{1'b1, 2'h2, 3'h4, 9'd128}, '{1'b1, 2'h2, 3'h5, 9'd256}, '{1'b1, 2'h2, 3'h0, 9'd0},
        '{1'b1, 2'h2, 3'h7, 9'd0}, '{1'b1, 2'h1, 3'h0, 9'd1}, '{1'b1, 2'h1, 3'h1, 9'd2},
        '{1'b1, 2'h1, 3'h2, 9'd4}, '{1'b1, 2'h1, 3'h3, 9'd8}, '{1'b1, 2'h1, 3'h4, 9'd0},
        '{1'b1, 2'h3, 3'h2, 9'd0}, '{1'b0, 2'h0, 3'h2, 9'd0}};

    dpcc_osc_model u_dpcc_osc_model (
        .o_internal_hf_osc(osc_int),
        .o_primary_hf_osc(osc_pri),
        .o_low_speed_osc(osc_low),
        .o_doubler_src_clk(osc_dbl)
    );
    dpcc_top u_dpcc_top (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_internal_hf_osc(osc_int),
        .i_primary_hf_osc(osc_pri),
        .i_low_speed_osc(osc_low),
        .i_doubler_src_clk(osc_dbl),
        .o_rdata(o_rdata),
        .o_booster_clk(o_booster_clk),
        .o_doubler_clk(o_doubler_clk),
        .o_analog(o_analog)
    );

    // 50 MHz clock
    initial
    begin
        forever #10 i_clock = ~i_clock;
    end
    // Raw edges of the selected source, the reference for divide ratios
    assign src_wave = (src_now == 2'h0) ? osc_int : (src_now == 2'h1) ? osc_low : (src_now == 2'h2) ? osc_pri : 1'b0;
    always @(posedge src_wave) src_edges++;
    // Output rises counted on the rising edge, read by tasks on the falling one
    always @(posedge i_clock)
    begin
        b_rises += (o_booster_clk === 1'b1 && b_prev === 1'b0);
        d_rises += (o_doubler_clk === 1'b1 && d_prev === 1'b0);
        b_prev = o_booster_clk;
        d_prev = o_doubler_clk;
        cycles++;
        // Hang guard, about twice the expected run length
        if (cycles == 60000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // Write strobe released on the edge that takes it
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr
    // Read data valid one cycle only, zero afterwards
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        check(o_rdata, e);
        @(negedge i_clock);
        check(o_rdata, 16'h0000);
    endtask : rd
    task reset_check();
        @(negedge i_clock);
        check({6'h00, o_analog}, 16'h0038);
        check({14'h0000, o_booster_clk, o_doubler_clk}, 16'h0000);
        rd(ADDR_BST_CLK, 16'h0000);
        rd(ADDR_DBL_CLK, 16'h0000);
        rd(ADDR_CORE_REG, 16'h0000);
        rd(ADDR_PWR0, 16'h0070);
    endtask : reset_check
    // Bounded wait for the next booster rise
    task wait_b();
        r0 = b_rises;
        k = 0;
        while (b_rises == r0 && k < 8000)
        begin
            @(negedge i_clock);
            k++;
        end
        // A wait that runs out is a mismatch
        check(16'(k < 8000), 16'h0001);
    endtask : wait_b
    // Skip the partial first period after the restart and one whole period, then count one period
    task clk_case(input dpcc_clk_type c);
        src_now = c.src;
        wr(ADDR_BST_CLK, {9'h000, c.div, c.src, 1'b0, c.gate});
        if (c.n == 9'd0)
        begin
            r0 = b_rises;
            repeat (400) @(negedge i_clock);
            check(16'(b_rises - r0), 16'h0000);
        end
        else
        begin
            wait_b();
            wait_b();
            e0 = src_edges;
            wait_b();
            check(16'(src_edges - e0), {7'h00, c.n});
        end
    endtask : clk_case
    task end_of_test();
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        reset_check();
        // Register rows: analogue image two edges after the write, then readback
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            repeat (2) @(posedge i_clock);
            @(negedge i_clock);
            check({6'h00, o_analog}, rows[i].analog);
            rd(rows[i].addr, rows[i].rdata);
        end
        // Write then read with no gap
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= ADDR_PWR0;
        i_wdata <= 16'h0031;
        @(posedge i_clock);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        check(o_rdata, 16'h0031);
        // Every source with each legal divide code and some reserved ones, reserved ones silent
        foreach (clks[i]) clk_case(clks[i]);
        wr(ADDR_BST_CLK, 16'h0000);
        // Doubler clock follows its source only while gated on
        wr(ADDR_DBL_CLK, 16'h0001);
        r0 = d_rises;
        repeat (1200) @(negedge i_clock);
        check(16'((d_rises - r0) inside {[99:101]}), 16'h0001);
        wr(ADDR_DBL_CLK, 16'h0000);
        repeat (4) @(negedge i_clock);
        r0 = d_rises;
        repeat (300) @(negedge i_clock);
        check(16'(d_rises - r0), 16'h0000);
        // Mid-run reset with fields away from defaults
        wr(ADDR_PWR0, 16'h03F7);
        wr(ADDR_CORE_REG, 16'h0020);
        // Both clocks running, booster high, as reset hits
        wr(ADDR_DBL_CLK, 16'h0001);
        wr(ADDR_BST_CLK, 16'h0021);
        wait_b();
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        repeat (3) @(negedge i_clock);
        check({6'h00, o_analog}, 16'h0038);
        check({14'h0000, o_booster_clk, o_doubler_clk}, 16'h0000);
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        reset_check();
        end_of_test();
    end
endmodule : dpcc_top_test
